/* common/hbridge_defines.svh */
// Purpose: Constants of the six-half-bridge serial control port.
// Assumes: Bit positions are those of the 16-bit serial words.
// Notes:   Definitions only; included by bare name.
`ifndef HBRIDGE_DEFINES_SVH
`define HBRIDGE_DEFINES_SVH

// ---------------------------------------------------------------------
// Word layout
// ---------------------------------------------------------------------
`define WORD_W        16
`define FRAME_BITS    5'h10
`define FRAME_OVER    5'h11
`define CNT_ZERO      5'h00
`define CNT_ONE       5'h01
`define CW_RESET      16'he000
`define CW_CLR        0
`define CW_SW_LO      1
`define CW_SW_HI      12
`define CW_OLD        13
`define CW_SCT        14
`define CW_SE         15
`define ST_WARN       0
`define ST_SW_LO      1
`define ST_SW_HI      12
`define ST_SC         13
`define ST_EN         14
`define ST_UV         15
`define ST_ALL_ONES   16'hffff
`define SW_N          12

// ---------------------------------------------------------------------
// Synchroniser lanes
// ---------------------------------------------------------------------
`define SYNC_W        20
`define SY_CS         0
`define SY_SCLK       1
`define SY_SDI        2
`define SY_HWEN       3
`define SY_SC         4
`define SY_UV         5
`define SY_OT         6
`define SY_WARN       7
`define SY_LD_LO      8
`define SY_LD_HI      19

`endif

/* common/hbridge_pkg.sv */
// Purpose: Types shared by the half-bridge serial control port.
// Assumes: Nothing beyond the defines header.
// Notes:   Holds the frame state type only.
package hbridge_pkg;

  // -------------------------------------------------------------------
  // Frame state
  // -------------------------------------------------------------------
  typedef enum logic [0:0] {
    LINK_IDLE  = 1'b0,
    LINK_FRAME = 1'b1
  } link_state_t;

endpackage

/* rtl/pin_sync.sv */
// Purpose: Two-flop synchroniser for asynchronous input lanes.
// Assumes: Each lane is a slow level relative to the system clock.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ns
`include "hbridge_defines.svh"

module pin_sync (
  // Clock and reset.
  input  wire logic               clk_sys_i,
  input  wire logic               reset_n_i,
  // Lanes.
  input  wire logic [`SYNC_W-1:0] async_i,
  output logic      [`SYNC_W-1:0] sync_o
);

  logic [`SYNC_W-1:0] stage1_r;
  logic [`SYNC_W-1:0] stage2_r;

  // -------------------------------------------------------------------
  // One pair of flops per lane; metastability settles in stage one.
  // -------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `SYNC_W; g = g + 1) begin : g_lane
      always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
          stage1_r[g] <= 1'b0;
          stage2_r[g] <= 1'b0;
        end else begin
          stage1_r[g] <= async_i[g];
          stage2_r[g] <= stage1_r[g];
        end
      end
    end
  endgenerate

  // Only the second stage leaves the module.
  assign sync_o = stage2_r;

endmodule

/* rtl/hbridge_serial_ctrl.sv */
// Purpose: Serial control port of a six-half-bridge load driver.
// Assumes: Link pins are asynchronous; the serial clock is far slower
//          than clk_sys_i and is found by sampling, not used as a clock.
// Notes:   Fault inputs are levels from the analog protection circuits.
`timescale 1ns/1ns
`include "hbridge_defines.svh"

// Function
// - Chip select falling starts a new frame.
// - New control word takes effect only at chip select rising.
// - Input bits are sampled on serial clock falling edges.
// - Data output is driven from chip select falling.
// - Data output changes only at chip select falling and on serial clock rising edges.
// - Data output is released while chip select is high.
// - Status word leaves least significant bit first, warning first.
// - Clear bit high clears supply, short and overheat indications.
// - Bits 1 to 12 switch low then high side per bridge.
// - Bit 13 low enables open-load detection.
// - Bit 14 high picks long short-circuit delay, low short.
// - Bit 15 is software run; serial port works in standby.
// - Disabled by software or pin turns all stages off.
// - Status bit 13 flags short circuit, bit 15 supply fail.
// - Overheat shutdown reports all sixteen status bits high.
module hbridge_serial_ctrl (
  // Clock and reset.
  input  wire logic                clk_sys_i,
  input  wire logic                reset_n_i,
  // Serial link.
  input  wire logic                cs_n_i,
  input  wire logic                sclk_i,
  input  wire logic                serial_in_line_i,
  output logic                     sdo_o,
  output logic                     sdo_oe_o,
  // Enable pin and protection levels.
  input  wire logic                hw_enable_i,
  input  wire logic                short_event_i,
  input  wire logic                supply_low_i,
  input  wire logic                overheat_i,
  input  wire logic                thermal_warning_i,
  input  wire logic [`SW_N-1:0]    load_status_i,
  // Driver controls.
  output logic      [`SW_N-1:0]    switch_on_o,
  output logic                     open_load_en_o,
  output logic                     long_delay_o,
  output logic                     enabled_o,
  output hbridge_pkg::link_state_t link_state_o
);
  import hbridge_pkg::*;

  // -------------------------------------------------------------------
  // Synchronised inputs
  // -------------------------------------------------------------------
  logic [`SYNC_W-1:0] async_w;
  logic [`SYNC_W-1:0] sync_w;

  assign async_w = {load_status_i, thermal_warning_i, overheat_i,
                    supply_low_i, short_event_i, hw_enable_i,
                    serial_in_line_i, sclk_i, cs_n_i};

  pin_sync u_sync (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .async_i   (async_w),
    .sync_o    (sync_w)
  );

  logic cs_s;
  logic sclk_s;
  logic sdi_s;
  logic hwen_s;
  logic sc_s;
  logic uv_s;
  logic ot_s;
  logic [`SW_N-1:0] ld_s;
  assign cs_s   = sync_w[`SY_CS];
  assign sclk_s = sync_w[`SY_SCLK];
  assign sdi_s  = sync_w[`SY_SDI];
  assign hwen_s = sync_w[`SY_HWEN];
  assign sc_s   = sync_w[`SY_SC];
  assign uv_s   = sync_w[`SY_UV];
  assign ot_s   = sync_w[`SY_OT];
  assign ld_s   = sync_w[`SY_LD_HI:`SY_LD_LO];

  // Edge decode, used for both chip select and serial clock.
  function automatic logic fell(input logic prev, input logic cur);
    fell = prev & ~cur;
  endfunction

  // -------------------------------------------------------------------
  // Link group: state, shift registers, data output
  // -------------------------------------------------------------------
  link_state_t        state_r, state_nxt;
  logic               cs_prev_r, sclk_prev_r;
  logic [4:0]         cnt_r, cnt_nxt;
  logic [`WORD_W-1:0] rx_r, rx_nxt;
  logic [`WORD_W-1:0] tx_r, tx_nxt;
  logic               sdo_nxt;
  logic               oe_nxt;
  logic               cs_fall, cs_rise, sclk_fall, sclk_rise;
  logic               take_w;
  logic [`WORD_W-1:0] status_w;

  assign cs_fall   = fell(cs_prev_r, cs_s);
  assign cs_rise   = fell(cs_s, cs_prev_r);
  assign sclk_fall = fell(sclk_prev_r, sclk_s);
  assign sclk_rise = fell(sclk_s, sclk_prev_r);
  assign take_w    = cs_rise && (state_r == LINK_FRAME)
                     && (cnt_r == `FRAME_BITS);

  // Frame sequencing. The first bit is already on the line at select
  // falling, so the rising edge before the first falling edge must not
  // advance it; shifting waits until one bit has been taken.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    rx_nxt    = rx_r;
    tx_nxt    = tx_r;
    sdo_nxt   = sdo_o;
    oe_nxt    = ~cs_s && (state_r == LINK_FRAME || cs_fall);
    case (state_r)
      LINK_IDLE: begin
        if (cs_fall) begin
          state_nxt = LINK_FRAME;
          cnt_nxt   = `CNT_ZERO;
          tx_nxt    = status_w;
          sdo_nxt   = status_w[`ST_WARN];
        end
      end
      LINK_FRAME: begin
        if (cs_rise) begin
          state_nxt = LINK_IDLE;
        end else begin
          if (sclk_fall && cnt_r != `FRAME_OVER) begin
            cnt_nxt = cnt_r + `CNT_ONE;
            // Bits past sixteen are counted but not shifted, so that a
            // long frame is refused at select rising.
            if (cnt_r < `FRAME_BITS) begin
              rx_nxt = {sdi_s, rx_r[`WORD_W-1:1]};
            end
          end
          if (sclk_rise && cnt_r != `CNT_ZERO) begin
            tx_nxt  = {1'b0, tx_r[`WORD_W-1:1]};
            sdo_nxt = tx_r[1];
          end
        end
      end
      default: state_nxt = LINK_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r     <= LINK_IDLE;
      cs_prev_r   <= 1'b0; // Matches the synchroniser, so no false fall.
      sclk_prev_r <= 1'b0;
      cnt_r       <= `CNT_ZERO;
      rx_r        <= '0;
      tx_r        <= '0;
      sdo_o       <= 1'b0;
      sdo_oe_o    <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      cs_prev_r   <= cs_s;
      sclk_prev_r <= sclk_s;
      cnt_r       <= cnt_nxt;
      rx_r        <= rx_nxt;
      tx_r        <= tx_nxt;
      sdo_o       <= sdo_nxt;
      sdo_oe_o    <= oe_nxt;
    end
  end

  assign link_state_o = state_r;

  // -------------------------------------------------------------------
  // Control group: control word, sticky flags, driver outputs
  // -------------------------------------------------------------------
  logic [`WORD_W-1:0] ctrl_r, ctrl_nxt;
  logic               sc_flag_r, sc_flag_nxt;
  logic               uv_flag_r, uv_flag_nxt;
  logic               ot_flag_r, ot_flag_nxt;
  logic               clr_w;
  logic               run_w;
  logic [`SW_N-1:0]   sw_stat_w;

  // A short frame is ignored whole, clear bit included.
  assign clr_w = take_w && rx_r[`CW_CLR];
  assign run_w = ctrl_r[`CW_SE] && hwen_s;

  // Flags are sticky; a fault present in the clearing cycle survives.
  always_comb begin
    ctrl_nxt    = take_w ? rx_r : ctrl_r;
    sc_flag_nxt = sc_s | (sc_flag_r & ~clr_w);
    uv_flag_nxt = uv_s | (uv_flag_r & ~clr_w);
    ot_flag_nxt = ot_s | (ot_flag_r & ~clr_w);
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_r         <= `CW_RESET;
      sc_flag_r      <= 1'b0;
      uv_flag_r      <= 1'b0;
      ot_flag_r      <= 1'b0;
      switch_on_o    <= '0;
      open_load_en_o <= 1'b0;
      long_delay_o   <= 1'b1;
      enabled_o      <= 1'b0;
    end else begin
      ctrl_r         <= ctrl_nxt;
      sc_flag_r      <= sc_flag_nxt;
      uv_flag_r      <= uv_flag_nxt;
      ot_flag_r      <= ot_flag_nxt;
      switch_on_o    <= ctrl_r[`CW_SW_HI:`CW_SW_LO]
                        & {`SW_N{run_w}};
      open_load_en_o <= ~ctrl_r[`CW_OLD];
      long_delay_o   <= ctrl_r[`CW_SCT];
      enabled_o      <= run_w;
    end
  end

  // -------------------------------------------------------------------
  // Status word
  // -------------------------------------------------------------------
  // With open-load detection on, the analog comparators report per
  // switch; otherwise the bit echoes whether the stage is on.
  assign sw_stat_w = ctrl_r[`CW_OLD] ? switch_on_o : ld_s;

  always_comb begin
    status_w             = '0;
    status_w[`ST_WARN]   = sync_w[`SY_WARN];
    status_w[`ST_SW_HI:`ST_SW_LO] = sw_stat_w;
    status_w[`ST_SC]     = sc_flag_r;
    status_w[`ST_EN]     = enabled_o;
    status_w[`ST_UV]     = uv_flag_r;
    if (ot_flag_r) begin
      status_w = `ST_ALL_ONES;
    end
  end

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  a_apply_only_rise: assert property (
    !$past(take_w) |-> $stable(ctrl_r))
    else $error("Control word changed outside select rising.");
  a_apply_full_word: assert property (
    take_w |=> ctrl_r == $past(rx_r))
    else $error("Control word differs from shifted word.");
  a_sample_on_fall: assert property (
    state_r == LINK_FRAME && sclk_fall && !cs_rise
      && cnt_r < `FRAME_BITS |=> rx_r[`WORD_W-1] == $past(sdi_s))
    else $error("Input bit not taken at clock falling.");
  a_drive_at_start: assert property (
    cs_fall |=> sdo_oe_o ##1 sdo_oe_o)
    else $error("Data output not driven after select falling.");
  a_first_status_bit: assert property (
    state_r == LINK_IDLE && cs_fall |=> sdo_o == $past(status_w[0]))
    else $error("First status bit wrong.");
  a_hold_between: assert property (
    !$past(sclk_rise) && !$past(cs_fall) |-> $stable(sdo_o))
    else $error("Data output moved without clock rising.");
  a_release_high: assert property (
    cs_s |=> !sdo_oe_o)
    else $error("Data output driven while select high.");
  a_clear_flags: assert property (
    clr_w && !sc_s && !uv_s |=> !sc_flag_r && !uv_flag_r)
    else $error("Clear bit did not clear flags.");
  a_switch_map: assert property (
    run_w |=> switch_on_o == $past(ctrl_r[`CW_SW_HI:`CW_SW_LO]))
    else $error("Switch outputs do not follow control bits.");
  a_open_load_sel: assert property (
    ##1 open_load_en_o == !$past(ctrl_r[`CW_OLD]))
    else $error("Open-load enable polarity wrong.");
  a_delay_select: assert property (
    ##1 long_delay_o == $past(ctrl_r[`CW_SCT]))
    else $error("Delay select wrong.");
  a_soft_standby: assert property (
    !ctrl_r[`CW_SE] |=> !enabled_o)
    else $error("Standby bit did not disable.");
  a_all_off: assert property (
    !run_w |=> switch_on_o == '0)
    else $error("Stage on while disabled.");
  a_short_flag: assert property (
    sc_s |=> sc_flag_r && (ot_flag_r || status_w[`ST_SC]))
    else $error("Short circuit not flagged.");
  a_overheat_ones: assert property (
    ot_flag_r |-> status_w == `ST_ALL_ONES)
    else $error("Overheat not reported as all ones.");

  c_full_frame: cover property (take_w);
  c_clear_frame: cover property (clr_w && sc_flag_r);
  c_short_frame: cover property (cs_rise && !take_w
                                 && state_r == LINK_FRAME);
  c_standby_pin: cover property (ctrl_r[`CW_SE] && !hwen_s);

endmodule

/* verification/host_model.sv */
// Purpose: Host side of the serial link, sending and reading frames.
// Assumes: Serial clock of 160 ns made from 4 system clocks per phase.
// Notes:   Data in idles low, as its pull-down would hold it.
`timescale 1ns/1ns

module host_model (
  // Clock.
  input  wire logic clk_sys_i,
  // Link lines driven by the host.
  output logic      cs_n_o,
  output logic      sclk_o,
  output logic      sdi_o,
  // Data out of the device.
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i
);
  // A released data line reads as the inverse of its last bit, so a
  // sample taken while the device does not drive it is caught.
  logic line_w;
  assign line_w = sdo_oe_i ? sdo_i : ~sdo_i;

  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o  = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // One frame of n clocks; bad marks a released or wavering data out.
  task automatic frame(input logic [16:0] w, input int n,
                       output logic [15:0] st, output logic bad);
    logic a;
    bad = 1'b0;
    st  = 16'h0000;
    cs_n_o <= 1'b0;
    tick(8);
    for (int i = 0; i < n; i++) begin
      sclk_o <= 1'b1;
      sdi_o  <= w[i];
      tick(4);
      sclk_o <= 1'b0;
      tick(2);
      a = line_w;
      tick(2);
      if (i < 16) st[i] = line_w;
      if (a !== line_w || sdo_oe_i !== 1'b1) bad = 1'b1;
    end
    // Select rises with the clock low, as the device expects.
    cs_n_o <= 1'b1;
    sdi_o  <= 1'b0;
    tick(10);
  endtask
endmodule

/* verification/tb.sv */
// Purpose: Self-checking bench of the half-bridge serial control port.
// Assumes: Fault levels pass a 2-flop synchroniser before use.
// Notes:   Each scenario checks its own results before returning.
`timescale 1ns/1ns

module tb;
  import hbridge_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        cs_n_i, sclk_i, serial_in_line_i, sdo_o, sdo_oe_o;
  logic        hw_enable_i = 1'b1;
  logic        short_event_i = 1'b0;
  logic        supply_low_i = 1'b0;
  logic        overheat_i = 1'b0;
  logic        thermal_warning_i = 1'b0;
  logic [11:0] load_status_i = 12'h000;
  logic [11:0] switch_on_o;
  logic        open_load_en_o, long_delay_o, enabled_o;
  link_state_t link_state_o;
  int          fail_count = 0;
  int          cmp_count = 0;
  logic [15:0] st;

  // --------------------------------------------------------------------
  // Clock, device and host
  // --------------------------------------------------------------------
  always #10 clk_sys_i = ~clk_sys_i;

  hbridge_serial_ctrl hbridge_serial_ctrl_inst (.clk_sys_i, .reset_n_i,
    .cs_n_i, .sclk_i, .serial_in_line_i, .sdo_o, .sdo_oe_o, .hw_enable_i,
    .short_event_i, .supply_low_i, .overheat_i, .thermal_warning_i,
    .load_status_i, .switch_on_o, .open_load_en_o, .long_delay_o,
    .enabled_o, .link_state_o);

  host_model host_model_inst (.clk_sys_i, .cs_n_o(cs_n_i), .sclk_o(sclk_i),
    .sdi_o(serial_in_line_i), .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o));

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic check(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic give_verdict;
    if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic frame(input logic [16:0] w, input int n,
                       output logic [15:0] s);
    logic bad;
    host_model_inst.frame(w, n, s, bad);
    check("sdo_steady", 16'h0000, {15'h0000, bad});
    check("sdo_oe_idle", 16'h0000, {15'h0000, sdo_oe_o});
  endtask

  // Outputs expected from an applied word w and the enable pin level hw.
  task automatic outs(input logic [15:0] w, input logic hw);
    logic en;
    en = w[15] & hw;
    check("switch_on", {4'h0, w[12:1] & {12{en}}},
          {4'h0, switch_on_o});
    check("open_load", {15'h0, ~w[13]}, {15'h0, open_load_en_o});
    check("long_delay", {15'h0, w[14]}, {15'h0, long_delay_o});
    check("enabled", {15'h0, en}, {15'h0, enabled_o});
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic s_reset;
    outs(16'he000, 1'b1);
    check("oe_reset", 16'h0000, {15'h0, sdo_oe_o});
  endtask

  // Outputs must hold the old word until select rises.
  task automatic s_write;
    logic [15:0] s;
    fork
      frame({1'b0, 16'ha554}, 16, s);
      begin
        tick(80);
        check("sw_mid", 16'h0000, {4'h0, switch_on_o});
        check("en_mid", 16'h0001, {15'h0, enabled_o});
        check("in_frame", 16'h0001, {15'h0, link_state_o});
      end
    join
    outs(16'ha554, 1'b1);
  endtask

  task automatic s_status;
    thermal_warning_i <= 1'b1;
    tick(8);
    frame({1'b0, 16'ha554}, 16, st);
    check("status", {3'b010, 12'h2aa, 1'b1}, st);
    load_status_i <= 12'h3c5;
    frame({1'b0, 16'h8554}, 16, st);
    frame({1'b0, 16'h8554}, 16, st);
    check("status_ol", {3'b010, 12'h3c5, 1'b1}, st);
    outs(16'h8554, 1'b1);
    thermal_warning_i <= 1'b0;
    frame({1'b0, 16'ha554}, 16, st);
  endtask

  // Sticky flags appear, then one clear frame removes them.
  task automatic s_flags;
    short_event_i <= 1'b1;
    supply_low_i  <= 1'b1;
    tick(4);
    short_event_i <= 1'b0;
    supply_low_i  <= 1'b0;
    tick(8);
    frame({1'b0, 16'ha554}, 16, st);
    check("flags_set", {3'b111, 12'h2aa, 1'b0}, st);
    frame({1'b0, 16'ha555}, 16, st);
    frame({1'b0, 16'ha554}, 16, st);
    check("flags_clr", {3'b010, 12'h2aa, 1'b0}, st);
    overheat_i <= 1'b1;
    tick(4);
    overheat_i <= 1'b0;
    tick(8);
    frame({1'b0, 16'ha554}, 16, st);
    check("overheat", 16'hffff, st);
    frame({1'b0, 16'ha555}, 16, st);
    frame({1'b0, 16'ha554}, 16, st);
    check("heat_clr", {3'b010, 12'h2aa, 1'b0}, st);
  endtask

  // Short and long frames are dropped whole.
  task automatic s_refuse;
    frame({1'b0, 16'h0000}, 15, st);
    outs(16'ha554, 1'b1);
    frame({1'b1, 16'h0000}, 17, st);
    outs(16'ha554, 1'b1);
  endtask

  task automatic s_standby;
    frame({1'b0, 16'h2554}, 16, st);
    outs(16'h2554, 1'b1);
    frame({1'b0, 16'ha554}, 16, st);
    check("stby_stat", 16'h0000, st);
    outs(16'ha554, 1'b1);
    hw_enable_i <= 1'b0;
    tick(8);
    outs(16'ha554, 1'b0);
    hw_enable_i <= 1'b1;
    tick(8);
    outs(16'ha554, 1'b1);
  endtask

  // --------------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------------
  initial begin
    tick(5);
    reset_n_i <= 1'b1;
    tick(6);
    s_reset;
    s_write;
    s_status;
    s_flags;
    s_refuse;
    s_standby;
    give_verdict;
  end

  // The run needs about 2250 clocks; a hang far beyond that is cut short.
  initial begin
    tick(20000);
    fail_count++;
    give_verdict;
  end
endmodule
